/* File: design/overrange_defs.svh */
// Purpose: Offsets, field positions, reset values and widths for the overrange/sync register slice
// Assumes: Register port addresses are the byte addresses of the serial control port
// Notes:   Definitions only
`ifndef OVERRANGE_DEFS_SVH
`define OVERRANGE_DEFS_SVH

// ****************************************
// Widths
// ****************************************
`define REG_ADDR_W            15
`define REG_DATA_W            8
`define OVR_FLAG_W            24
`define OVR_BYTE_W            8
`define TMODE_W               4

// ****************************************
// Offsets
// ****************************************
`define ADDR_OVR_BYTE9        15'h01a2
`define ADDR_OVR_BYTE10       15'h01a3
`define ADDR_OVR_BYTE11       15'h01a4
`define ADDR_TP_OVERRIDE      15'h01b0
`define ADDR_SYSREF_SYNC      15'h01c0

// ****************************************
// Fields and reset values
// ****************************************
`define TP_OVERRIDE_BIT       1
`define TP_OVERRIDE_RST       1'h0
`define OSC_RST_ALL_BIT       3
`define OSC_RST_ALL_RST       1'h1
`define SYNC_RSVD_VAL         4'h1
`define TP_OVERRIDE_SEL       4'hf

`endif

/* File: design/overrange_pkg.sv */
// Purpose: Shared types of the overrange/sync register slice
// Assumes: Nothing
// Notes:   One-hot register select
`default_nettype none
package overrange_pkg;
  typedef enum logic [5:0] {
    SEL_NONE   = 6'h01,
    SEL_OVR9   = 6'h02,
    SEL_OVR10  = 6'h04,
    SEL_OVR11  = 6'h08,
    SEL_TP     = 6'h10,
    SEL_SYNC   = 6'h20
  } reg_sel_t;
endpackage
`default_nettype wire

/* File: design/sticky_flag_byte.sv */
// Purpose: Eight sticky overrange flags
// Assumes: Events and clears come from logic on i_core_clk
// Notes:   A set in the same cycle as its clear wins
`default_nettype none
module sticky_flag_byte (
  input  wire logic       i_core_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_clk_en,
  input  wire logic [7:0] i_event,
  input  wire logic [7:0] i_clear,
  output logic      [7:0] o_flags
);
  logic [7:0] flags_reg;
  logic [7:0] flags_next;

  assign flags_next = i_event | (flags_reg & ~i_clear);

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      flags_reg <= 8'h00;
    end else if (i_clk_en) begin
      flags_reg <= flags_next;
    end
  end

  assign o_flags = flags_reg;

  AST_SET_WINS: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_clk_en && |(i_event & i_clear)) |=> ((o_flags & $past(i_event)) == $past(i_event)))
    else $error("Flag lost when set and clear coincide");
endmodule // sticky_flag_byte
`default_nettype wire

/* File: design/overrange_status_sync_ctrl.sv */
// Purpose: Overrange status bytes 9..11, test-pattern override and SYSREF oscillator reset mode
// Assumes: Register port is the back end of the serial control port, on i_core_clk
// Notes:   Notes on behaviour below
`include "overrange_defs.svh"
`default_nettype none
module overrange_status_sync_ctrl (
  input  wire logic                     i_core_clk,
  input  wire logic                     i_nrst,
  input  wire logic                     i_clk_en,
  input  wire logic [`REG_ADDR_W-1:0]   i_reg_addr,
  input  wire logic                     i_reg_wr,
  input  wire logic                     i_reg_rd,
  input  wire logic [`REG_DATA_W-1:0]   i_reg_wdata,
  output logic      [`REG_DATA_W-1:0]   o_reg_rdata,
  input  wire logic [`OVR_FLAG_W-1:0]   i_ovr_event,
  input  wire logic [`OVR_FLAG_W-1:0]   i_clear_bits,
  input  wire logic [`TMODE_W-1:0]      i_fmt_tmode_sel,
  output logic      [`TMODE_W-1:0]      o_fmt_tmode_sel,
  output logic                          o_tp_override,
  input  wire logic                     i_sysref_pulse,
  input  wire logic                     i_sysref_resynced,
  output logic                          o_osc_reset,
  output logic                          o_osc_reset_every_sysref
);

  // ****************************************
  // Decode
  // ****************************************
  function automatic overrange_pkg::reg_sel_t reg_sel(input logic [`REG_ADDR_W-1:0] addr);
    if (addr == `ADDR_OVR_BYTE9) begin
      reg_sel = overrange_pkg::SEL_OVR9;
    end else if (addr == `ADDR_OVR_BYTE10) begin
      reg_sel = overrange_pkg::SEL_OVR10;
    end else if (addr == `ADDR_OVR_BYTE11) begin
      reg_sel = overrange_pkg::SEL_OVR11;
    end else if (addr == `ADDR_TP_OVERRIDE) begin
      reg_sel = overrange_pkg::SEL_TP;
    end else if (addr == `ADDR_SYSREF_SYNC) begin
      reg_sel = overrange_pkg::SEL_SYNC;
    end else begin
      reg_sel = overrange_pkg::SEL_NONE;
    end
  endfunction

  overrange_pkg::reg_sel_t       sel;
  logic [`OVR_FLAG_W-1:0]        overrange_sticky_flags;
  logic                          tp_override_reg;
  logic                          osc_reset_every_sysref_reg;
  logic [`REG_DATA_W-1:0]        rdata_next;

  assign sel = reg_sel(i_reg_addr);

  // ****************************************
  // Sticky flags
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_byte
      sticky_flag_byte u_flags (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_clk_en   (i_clk_en),
        .i_event    (i_ovr_event[g*8 +: 8]),
        .i_clear    (i_clear_bits[g*8 +: 8]),
        .o_flags    (overrange_sticky_flags[g*8 +: 8])
      );
    end
  endgenerate

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tp_override_reg <= `TP_OVERRIDE_RST;
    end else if (i_clk_en && i_reg_wr && sel == overrange_pkg::SEL_TP) begin
      tp_override_reg <= i_reg_wdata[`TP_OVERRIDE_BIT];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      osc_reset_every_sysref_reg <= `OSC_RST_ALL_RST;
    end else if (i_clk_en && i_reg_wr && sel == overrange_pkg::SEL_SYNC) begin
      osc_reset_every_sysref_reg <= i_reg_wdata[`OSC_RST_ALL_BIT];
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Status bytes are read-only; reads have no side effect on the flags
  always_comb begin
    rdata_next = 8'h00;
    case (sel)
      overrange_pkg::SEL_OVR9:  rdata_next = overrange_sticky_flags[7:0];
      overrange_pkg::SEL_OVR10: rdata_next = overrange_sticky_flags[15:8];
      overrange_pkg::SEL_OVR11: rdata_next = overrange_sticky_flags[23:16];
      overrange_pkg::SEL_TP:    rdata_next = {6'h00, tp_override_reg, 1'b0};
      overrange_pkg::SEL_SYNC:  rdata_next = {`SYNC_RSVD_VAL, osc_reset_every_sysref_reg, 3'h0};
      default:                  rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_clk_en && i_reg_rd) begin
      o_reg_rdata <= rdata_next;
    end
  end

  // ****************************************
  // Test-pattern selection
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_fmt_tmode_sel <= 4'h0;
    end else if (i_clk_en) begin
      o_fmt_tmode_sel <= tp_override_reg ? `TP_OVERRIDE_SEL : i_fmt_tmode_sel;
    end
  end

  assign o_tp_override            = tp_override_reg;
  assign o_osc_reset_every_sysref = osc_reset_every_sysref_reg;

  // ****************************************
  // Oscillator reset on SYSREF
  // ****************************************
  // Resync qualifier must arrive in the same cycle as the pulse; no stretching is done
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_osc_reset <= 1'b0;
    end else if (i_clk_en) begin
      o_osc_reset <= i_sysref_pulse && (osc_reset_every_sysref_reg || i_sysref_resynced);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  AST_FLAG_SETS: assert property ((i_clk_en && |i_ovr_event) |=>
    ((overrange_sticky_flags & $past(i_ovr_event)) == $past(i_ovr_event)))
    else $error("Overrange event did not set its flag");
  AST_FLAG_STICKY: assert property (i_clk_en |=>
    ((($past(overrange_sticky_flags) & ~$past(i_clear_bits)) & ~overrange_sticky_flags) == 24'h00_0000))
    else $error("Flag dropped without a clear");
  AST_FLAG_CLEARS: assert property (i_clk_en |=>
    ((overrange_sticky_flags & $past(i_clear_bits) & ~$past(i_ovr_event)) == 24'h00_0000))
    else $error("Clear did not drop the flag");
  AST_READ_BYTE9: assert property ((i_clk_en && i_reg_rd && i_reg_addr == `ADDR_OVR_BYTE9) |=>
    (o_reg_rdata == $past(overrange_sticky_flags[7:0])))
    else $error("Byte 9 read mismatch");
  AST_READ_BYTE11: assert property ((i_clk_en && i_reg_rd && i_reg_addr == `ADDR_OVR_BYTE11) |=>
    (o_reg_rdata == $past(overrange_sticky_flags[23:16])))
    else $error("Byte 11 read mismatch");
  AST_TP_OVERRIDE: assert property ((i_clk_en && tp_override_reg) |=>
    (o_fmt_tmode_sel == `TP_OVERRIDE_SEL))
    else $error("Override did not replace test mode");
  AST_TP_PASS: assert property ((i_clk_en && !tp_override_reg) |=>
    (o_fmt_tmode_sel == $past(i_fmt_tmode_sel)))
    else $error("Test mode altered without override");
  AST_OSC_ALL: assert property ((i_clk_en && i_sysref_pulse && osc_reset_every_sysref_reg) |=>
    o_osc_reset)
    else $error("Missing oscillator reset in all-SYSREF mode");
  AST_OSC_RESYNC: assert property ((i_clk_en && i_sysref_pulse && !osc_reset_every_sysref_reg) |=>
    (o_osc_reset == $past(i_sysref_resynced)))
    else $error("Oscillator reset not tied to resync");
  AST_OSC_QUIET: assert property ((i_clk_en && !i_sysref_pulse) |=> !o_osc_reset)
    else $error("Oscillator reset without SYSREF");

  // ****************************************
  // Register port checks
  // ****************************************
  AST_READ_BYTE10: assert property ((i_clk_en && i_reg_rd && i_reg_addr == `ADDR_OVR_BYTE10) |=>
    (o_reg_rdata == $past(overrange_sticky_flags[15:8])))
    else $error("Byte 10 read mismatch");
  AST_READ_TP: assert property ((i_clk_en && i_reg_rd && i_reg_addr == `ADDR_TP_OVERRIDE) |=>
    (o_reg_rdata == {6'h00, $past(tp_override_reg), 1'b0}))
    else $error("Override register read mismatch");
  AST_READ_SYNC: assert property ((i_clk_en && i_reg_rd && i_reg_addr == `ADDR_SYSREF_SYNC) |=>
    (o_reg_rdata == {`SYNC_RSVD_VAL, $past(osc_reset_every_sysref_reg), 3'h0}))
    else $error("Sync control read mismatch");
  AST_READ_UNMAPPED: assert property ((i_clk_en && i_reg_rd && i_reg_addr != `ADDR_OVR_BYTE9
    && i_reg_addr != `ADDR_OVR_BYTE10 && i_reg_addr != `ADDR_OVR_BYTE11
    && i_reg_addr != `ADDR_TP_OVERRIDE && i_reg_addr != `ADDR_SYSREF_SYNC) |=> (o_reg_rdata == 8'h00))
    else $error("Unmapped read returned data");

  // Only a taken read may move the read data, so a stale byte never looks fresh
  AST_RDATA_HOLD: assert property (!(i_clk_en && i_reg_rd) |=> $stable(o_reg_rdata))
    else $error("Read data moved without a read");
  AST_TP_WRITE: assert property ((i_clk_en && i_reg_wr && i_reg_addr == `ADDR_TP_OVERRIDE) |=>
    (o_tp_override == $past(i_reg_wdata[`TP_OVERRIDE_BIT])))
    else $error("Override write not taken");
  AST_MODE_WRITE: assert property ((i_clk_en && i_reg_wr && i_reg_addr == `ADDR_SYSREF_SYNC) |=>
    (o_osc_reset_every_sysref == $past(i_reg_wdata[`OSC_RST_ALL_BIT])))
    else $error("Mode write not taken");

  // A low enable must freeze everything, or a stalled converter clock would lose or invent events
  AST_FROZEN: assert property (!i_clk_en |=> ($stable(o_reg_rdata) && $stable(overrange_sticky_flags)
    && $stable(o_fmt_tmode_sel) && $stable(o_osc_reset) && $stable(o_tp_override)
    && $stable(o_osc_reset_every_sysref)))
    else $error("State moved while the clock enable was low");

  COV_SET_CLEAR: cover property (i_clk_en && |(i_ovr_event & i_clear_bits));
  COV_OVERRIDE: cover property (i_clk_en && tp_override_reg);
  COV_RESYNC_ONLY: cover property (i_clk_en && i_sysref_pulse && !osc_reset_every_sysref_reg && !i_sysref_resynced);
  COV_READ_FLAG: cover property (i_clk_en && i_reg_rd && sel == overrange_pkg::SEL_OVR10);
  COV_FROZEN: cover property (!i_clk_en && i_reg_wr);
endmodule // overrange_status_sync_ctrl
`default_nettype wire

/* File: dv/tb.sv */
// Purpose: Self-checking bench for the overrange status and SYSREF sync register slice
// Assumes: Parallel register port, one strobe cycle per access, registered read data
// Notes:   All inputs driven by non-blocking assignment at the rising edge
`include "overrange_defs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_core_clk = 1'b0;
  logic        i_nrst     = 1'b0;
  logic        i_clk_en   = 1'b1;
  logic [14:0] i_reg_addr = 15'h0000;
  logic        i_reg_wr   = 1'b0;
  logic        i_reg_rd   = 1'b0;
  logic [7:0]  i_reg_wdata = 8'h00;
  logic [7:0]  o_reg_rdata;
  logic [23:0] i_ovr_event = 24'h00_0000;
  logic [23:0] i_clear_bits = 24'h00_0000;
  logic [3:0]  i_fmt_tmode_sel = 4'h5;
  logic [3:0]  o_fmt_tmode_sel;
  logic        o_tp_override, o_osc_reset, o_osc_reset_every_sysref;
  logic        i_sysref_pulse = 1'b0;
  logic        i_sysref_resynced = 1'b0;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cycles = 0;
  always #2.5 i_core_clk = ~i_core_clk;
  overrange_status_sync_ctrl u_dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_clk_en(i_clk_en),
    .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_ovr_event(i_ovr_event), .i_clear_bits(i_clear_bits),
    .i_fmt_tmode_sel(i_fmt_tmode_sel), .o_fmt_tmode_sel(o_fmt_tmode_sel), .o_tp_override(o_tp_override),
    .i_sysref_pulse(i_sysref_pulse), .i_sysref_resynced(i_sysref_resynced), .o_osc_reset(o_osc_reset),
    .o_osc_reset_every_sysref(o_osc_reset_every_sysref));
  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(posedge i_core_clk) begin i_reg_addr <= a; i_reg_wdata <= d; i_reg_wr <= 1'b1; end
    @(posedge i_core_clk) i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] exp);
    @(posedge i_core_clk) begin i_reg_addr <= a; i_reg_rd <= 1'b1; end
    @(posedge i_core_clk) i_reg_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), exp, o_reg_rdata);
  endtask
  // Event or clear held for exactly one enabled edge
  task automatic pulse_in(input logic [23:0] ev, input logic [23:0] clr);
    @(posedge i_core_clk) begin i_ovr_event <= ev; i_clear_bits <= clr; end
    @(posedge i_core_clk) begin i_ovr_event <= 24'h00_0000; i_clear_bits <= 24'h00_0000; end
  endtask
  task automatic sysref(input logic resync, input logic exp);
    @(posedge i_core_clk) begin i_sysref_pulse <= 1'b1; i_sysref_resynced <= resync; end
    @(posedge i_core_clk) begin i_sysref_pulse <= 1'b0; i_sysref_resynced <= 1'b0; end
    #1 chk("osc reset", {7'h00, exp}, {7'h00, o_osc_reset});
    @(posedge i_core_clk) #1 chk("osc reset end", 8'h00, {7'h00, o_osc_reset});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Generous ceiling: the sequence needs well under 300 cycles
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      end_of_test();
    end
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    rd(`ADDR_OVR_BYTE9, 8'h00);
    rd(`ADDR_OVR_BYTE11, 8'h00);
    rd(`ADDR_TP_OVERRIDE, 8'h00);
    rd(`ADDR_SYSREF_SYNC, 8'h18);
    rd(15'h01a5, 8'h00);
    chk("fmt sel pass", 8'h05, {4'h0, o_fmt_tmode_sel});
    chk("mode out reset", 8'h01, {7'h00, o_osc_reset_every_sysref});
    $display("test reset values done");
    pulse_in(24'h80_8001, 24'h00_0000);
    wr(`ADDR_OVR_BYTE10, 8'h00);
    rd(`ADDR_OVR_BYTE9, 8'h01);
    rd(`ADDR_OVR_BYTE10, 8'h80);
    rd(`ADDR_OVR_BYTE11, 8'h80);
    rd(`ADDR_OVR_BYTE11, 8'h80);
    pulse_in(24'h00_0000, 24'h00_8000);
    rd(`ADDR_OVR_BYTE10, 8'h00);
    rd(`ADDR_OVR_BYTE9, 8'h01);
    pulse_in(24'h80_0000, 24'h80_0000);
    rd(`ADDR_OVR_BYTE11, 8'h80);
    $display("test sticky flags done");
    wr(`ADDR_TP_OVERRIDE, 8'hff);
    rd(`ADDR_TP_OVERRIDE, 8'h02);
    @(posedge i_core_clk) #1;
    chk("override", 8'h01, {7'h00, o_tp_override});
    chk("fmt sel forced", 8'h0f, {4'h0, o_fmt_tmode_sel});
    wr(`ADDR_TP_OVERRIDE, 8'h00);
    @(posedge i_core_clk) i_fmt_tmode_sel <= 4'ha;
    repeat (2) @(posedge i_core_clk);
    #1 chk("fmt sel back", 8'h0a, {4'h0, o_fmt_tmode_sel});
    $display("test pattern override done");
    sysref(1'b0, 1'b1);
    wr(`ADDR_SYSREF_SYNC, 8'h00);
    rd(`ADDR_SYSREF_SYNC, 8'h10);
    chk("mode out", 8'h00, {7'h00, o_osc_reset_every_sysref});
    sysref(1'b0, 1'b0);
    sysref(1'b1, 1'b1);
    @(posedge i_core_clk) i_clk_en <= 1'b0;
    wr(`ADDR_SYSREF_SYNC, 8'h08);
    @(posedge i_core_clk) i_clk_en <= 1'b1;
    rd(`ADDR_SYSREF_SYNC, 8'h10);
    wr(`ADDR_SYSREF_SYNC, 8'h08);
    rd(`ADDR_SYSREF_SYNC, 8'h18);
    chk("mode out", 8'h01, {7'h00, o_osc_reset_every_sysref});
    $display("test sysref mode done");
    pulse_in(24'h00_0100, 24'h00_0000);
    wr(`ADDR_SYSREF_SYNC, 8'h00);
    rd(`ADDR_OVR_BYTE10, 8'h01);
    @(posedge i_core_clk) i_nrst <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    chk("rdata in reset", 8'h00, o_reg_rdata);
    i_nrst <= 1'b1;
    rd(`ADDR_OVR_BYTE10, 8'h00);
    rd(`ADDR_SYSREF_SYNC, 8'h18);
    chk("mode out after reset", 8'h01, {7'h00, o_osc_reset_every_sysref});
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule // tb
`default_nettype wire
